//--- logic/modem_setup_pkg.sv
// Purpose: Shared constants and types for the modem set-up register bank and its host.
// Assumes: One 250 MHz clock on both ends; serial command bus sent MSB first.
// Notes:   Register addresses are the command byte values seen on the serial bus.
package modem_setup_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] GENERAL_RESET_ADDR = 8'h01;
    localparam logic [7:0] SETUP_ADDR         = 8'hE0;
    localparam logic [7:0] TONE_ADDR          = 8'hE1;
    localparam logic [7:0] GAIN_ADDR          = 8'hE2;
    localparam logic [7:0] TX_BYTE_ADDR       = 8'hE3;
    localparam logic [7:0] FORMAT_ADDR        = 8'hE4;
    localparam logic [7:0] TX_MOD_ADDR        = 8'hE7;
    localparam logic [7:0] RX_DEMOD_ADDR      = 8'hE8;
    localparam logic [7:0] MASK_ADDR          = 8'hEE;

    // Slots of the register array inside the device.
    localparam logic [2:0] SLOT_SETUP    = 3'h0;
    localparam logic [2:0] SLOT_TONE     = 3'h1;
    localparam logic [2:0] SLOT_GAIN     = 3'h2;
    localparam logic [2:0] SLOT_TX_BYTE  = 3'h3;
    localparam logic [2:0] SLOT_FORMAT   = 3'h4;
    localparam logic [2:0] SLOT_TX_MOD   = 3'h5;
    localparam logic [2:0] SLOT_RX_DEMOD = 3'h6;
    localparam logic [2:0] SLOT_MASK     = 3'h7;
    localparam int         REG_COUNT     = 8;

    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // Field positions.
    localparam int SETUP_RESERVED_BIT = 7;
    localparam int SETUP_RELAY_BIT    = 6;
    localparam int SETUP_DETECT_LSB   = 4;
    localparam int SETUP_LOOP_LSB     = 2;
    localparam int SETUP_CLOCK_LSB    = 0;
    localparam int RX_BAND_BIT        = 0;
    localparam int RX_ENABLE_BIT      = 1;
    localparam int MASK_RING_BIT      = 6;

    typedef enum logic [1:0] {DET_PSK, DET_PROGRESS, DET_ANSWER, DET_OFF} detect_mode_type;
    typedef enum logic [1:0] {LOOP_NONE, LOOP_ANALOG, LOOP_DIGITAL, LOOP_RESERVED} loop_type;
    typedef enum logic [1:0] {CLK_ZERO_POWER, CLK_XTAL_LOW, CLK_XTAL_MID, CLK_XTAL_HIGH}
        clock_mode_type;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int MCLK_HZ        = 250_000_000;
    localparam int MODEM_BIT_RATE = 1200;
    localparam int BIT_CYCLES     = MCLK_HZ / MODEM_BIT_RATE;
    localparam int LOOP_TICK_W    = 18;
    localparam int SETTLE_TIME_MS = 20;
    localparam int SETTLE_CYCLES  = (MCLK_HZ / 1000) * SETTLE_TIME_MS;
    localparam int SETTLE_W       = 23;
    localparam int SCLK_HALF      = 4;
    localparam int BYTE_BITS      = 8;

    // Host command port map.
    localparam logic [3:0] HOST_TARGET_OFS = 4'h0;
    localparam logic [3:0] HOST_DATA_OFS   = 4'h1;
    localparam logic [3:0] HOST_RESET_OFS  = 4'h2;
    localparam logic [3:0] HOST_STATUS_OFS = 4'h3;
    localparam int         HOST_BUSY_BIT   = 0;
    localparam int         HOST_SETTLE_BIT = 1;

endpackage

//--- logic/serial_cmd_if.sv
// Purpose: Serial command bus between the host controller and the set-up register bank.
// Assumes: Host owns every wire; the bank only listens.
// Notes:   Data is taken on the rising edge of the serial clock while select is low.
`timescale 1ns/1ps
interface serial_cmd_if;
    logic sclk;
    logic cmd_data;
    logic sel_n;

    modport host (output sclk, output cmd_data, output sel_n);
    modport dev  (input sclk, input cmd_data, input sel_n);
endinterface

//--- logic/pin_sync.sv
// Purpose: Two-stage synchroniser for pins arriving from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_type;

    sync_type state_ff;
    sync_type nxt_state;

    always_comb begin
        nxt_state.meta   = d;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= {RESET_VALUE, RESET_VALUE};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign q = state_ff.stable;
endmodule

//--- logic/modem_setup_device.sv
// Purpose: Write-only set-up register bank of a 1200 bps modem on a serial command bus.
// Assumes: Status inputs and rx_byte_taken come from logic on mclk.
// Notes:   Bus pins are resynchronised, so the serial clock must stay well below mclk/4.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R1] Address byte then one data byte writes.
// [R2] General reset is an address-only command.
// [R3] General reset clears every register bit.
// [R4] Host keeps set-up bit 7 zero.
// [R5] Set-up bit 6 drives relay pull-down.
// [R6] Bits 5:4 select receive detection mode.
// [R7] Host sets band bit for detection mode.
// [R8] Host enables receive demodulator for detection.
// [R9] Loop code 00 normal; 11 unused.
// [R10] Code 01 loops transmit gain into receive.
// [R11] Code 10 serialises transmit byte to receiver.
// [R12] Bits 1:0 select crystal or zero power.
// [R13] Zero power stops all but bus, ring.
// [R14] Host waits 20 ms after zero power.
// [R15] Mask register gates each status onto interrupt.
// [R16] Unknown address writes change nothing.
module modem_setup_device #(
    parameter int BIT_CYCLES = modem_setup_pkg::BIT_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    serial_cmd_if.dev       bus,
    input  wire logic [7:0] status_in,
    input  wire logic       rx_byte_taken,
    output logic            hook_relay_output_o,
    output logic            hook_relay_output_oe,
    output logic            detect_mode_hi,
    output logic            detect_mode_lo,
    output logic            loop_sel_hi,
    output logic            loop_sel_lo,
    output logic            clock_sel_hi,
    output logic            clock_sel_lo,
    output logic            zero_power,
    output logic            analog_loop_route,
    output logic            rx_amp_break,
    output logic [7:0]      tone_ctrl,
    output logic [7:0]      gain_ctrl,
    output logic [7:0]      char_format,
    output logic [7:0]      tx_mod_mode,
    output logic [7:0]      rx_demod_mode,
    output logic            tx_byte_free,
    output logic [7:0]      loop_rx_byte,
    output logic            loop_rx_ready,
    output logic            irq
);
    localparam int TW = modem_setup_pkg::LOOP_TICK_W;

    typedef struct packed {
        logic                                           sclk_prev;
        logic [2:0]                                     bit_cnt;
        logic                                           got_addr;
        logic [7:0]                                     shift;
        logic [7:0]                                     addr;
        logic [modem_setup_pkg::REG_COUNT-1:0][7:0]     regs;
        logic                                           tx_pending;
        logic                                           lb_busy;
        logic [7:0]                                     lb_tx;
        logic [7:0]                                     lb_rx;
        logic [2:0]                                     lb_bits;
        logic [TW-1:0]                                  lb_tick;
        logic [7:0]                                     rx_byte;
        logic                                           rx_ready;
        logic                                           relay_oe;
        logic                                           zero_pwr;
        logic                                           analog_loop;
        logic                                           irq;
    } bank_type;

    bank_type   state_ff;
    bank_type   nxt_state;
    logic [2:0] pins;
    logic       s_sclk;
    logic       s_data;
    logic       s_sel_n;
    logic [7:0] shifted;
    logic [3:0] slot;
    logic [7:0] setup_v;
    logic [7:0] mask_v;

    // Decodes a command byte to {valid, slot}.
    function automatic logic [3:0] reg_slot(input logic [7:0] a);
        case (a)
            modem_setup_pkg::SETUP_ADDR:    return {1'b1, modem_setup_pkg::SLOT_SETUP};
            modem_setup_pkg::TONE_ADDR:     return {1'b1, modem_setup_pkg::SLOT_TONE};
            modem_setup_pkg::GAIN_ADDR:     return {1'b1, modem_setup_pkg::SLOT_GAIN};
            modem_setup_pkg::TX_BYTE_ADDR:  return {1'b1, modem_setup_pkg::SLOT_TX_BYTE};
            modem_setup_pkg::FORMAT_ADDR:   return {1'b1, modem_setup_pkg::SLOT_FORMAT};
            modem_setup_pkg::TX_MOD_ADDR:   return {1'b1, modem_setup_pkg::SLOT_TX_MOD};
            modem_setup_pkg::RX_DEMOD_ADDR: return {1'b1, modem_setup_pkg::SLOT_RX_DEMOD};
            modem_setup_pkg::MASK_ADDR:     return {1'b1, modem_setup_pkg::SLOT_MASK};
            default:                        return 4'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    pin_sync #(
        .WIDTH       (3),
        .RESET_VALUE (3'h1)
    ) u_pin_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({bus.sclk, bus.cmd_data, bus.sel_n}),
        .q    (pins)
    );

    assign s_sclk  = pins[2];
    assign s_data  = pins[1];
    assign s_sel_n = pins[0];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        shifted   = {state_ff.shift[6:0], s_data};
        slot      = reg_slot(state_ff.addr);
        nxt_state.sclk_prev = s_sclk;
        if (s_sel_n) begin
            nxt_state.bit_cnt  = 3'h0;
            nxt_state.got_addr = 1'b0;
        end else if (s_sclk && !state_ff.sclk_prev) begin
            nxt_state.shift   = shifted;
            nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
            if (state_ff.bit_cnt == 3'h7) begin
                if (!state_ff.got_addr) begin
                    // [R2] [R3] address-only reset
                    if (shifted == modem_setup_pkg::GENERAL_RESET_ADDR) begin
                        nxt_state.regs       = '0;
                        nxt_state.tx_pending = 1'b0;
                    end else begin
                        nxt_state.addr     = shifted;
                        nxt_state.got_addr = 1'b1;
                    end
                end else begin
                    nxt_state.got_addr = 1'b0;
                    // [R1] [R16] store decoded data
                    if (slot[3]) begin
                        nxt_state.regs[slot[2:0]] = shifted;
                        if (slot[2:0] == modem_setup_pkg::SLOT_TX_BYTE) begin
                            nxt_state.tx_pending = 1'b1;
                        end
                    end
                end
            end
        end

        setup_v = nxt_state.regs[modem_setup_pkg::SLOT_SETUP];
        mask_v  = nxt_state.regs[modem_setup_pkg::SLOT_MASK];

        // [R5] relay pull-down enable
        nxt_state.relay_oe = setup_v[modem_setup_pkg::SETUP_RELAY_BIT];
        // [R12] [R13] zero-power decode
        nxt_state.zero_pwr = setup_v[modem_setup_pkg::SETUP_CLOCK_LSB +: 2]
                             == modem_setup_pkg::CLK_ZERO_POWER;
        // [R9] [R10] analog loop path
        nxt_state.analog_loop = !nxt_state.zero_pwr
                                && setup_v[modem_setup_pkg::SETUP_LOOP_LSB +: 2]
                                   == modem_setup_pkg::LOOP_ANALOG;

        // [R11] digital loopback serialiser
        if (nxt_state.zero_pwr || setup_v[modem_setup_pkg::SETUP_LOOP_LSB +: 2]
                                  != modem_setup_pkg::LOOP_DIGITAL) begin
            nxt_state.lb_busy = 1'b0;
        end else if (!state_ff.lb_busy) begin
            if (state_ff.tx_pending) begin
                nxt_state.lb_busy    = 1'b1;
                nxt_state.tx_pending = nxt_state.tx_pending
                                       && nxt_state.regs[modem_setup_pkg::SLOT_TX_BYTE]
                                          != state_ff.regs[modem_setup_pkg::SLOT_TX_BYTE];
                nxt_state.lb_tx      = state_ff.regs[modem_setup_pkg::SLOT_TX_BYTE];
                nxt_state.lb_bits    = 3'h0;
                nxt_state.lb_tick    = '0;
            end
        end else if (state_ff.lb_tick == TW'(BIT_CYCLES - 1)) begin
            nxt_state.lb_tick = '0;
            nxt_state.lb_tx   = {1'b0, state_ff.lb_tx[7:1]};
            nxt_state.lb_rx   = {state_ff.lb_tx[0], state_ff.lb_rx[7:1]};
            nxt_state.lb_bits = state_ff.lb_bits + 3'h1;
            if (state_ff.lb_bits == 3'h7) begin
                nxt_state.lb_busy = 1'b0;
                nxt_state.rx_byte = {state_ff.lb_tx[0], state_ff.lb_rx[7:1]};
            end
        end else begin
            nxt_state.lb_tick = state_ff.lb_tick + TW'(1);
        end

        // A byte landing in the same cycle as the take is kept: set wins.
        nxt_state.rx_ready = (state_ff.rx_ready && !rx_byte_taken)
                             || (state_ff.lb_busy && !nxt_state.lb_busy
                                 && state_ff.lb_bits == 3'h7
                                 && state_ff.lb_tick == TW'(BIT_CYCLES - 1));

        // [R15] [R13] masked interrupt, ring only in zero power
        if (nxt_state.zero_pwr) begin
            mask_v = mask_v & (8'h01 << modem_setup_pkg::MASK_RING_BIT);
        end
        nxt_state.irq = |(status_in & mask_v);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The pin only ever pulls low; the enable carries the relay state.
    assign hook_relay_output_o  = 1'b0;
    assign hook_relay_output_oe = state_ff.relay_oe;
    // [R6] detection mode field
    assign detect_mode_hi = state_ff.regs[modem_setup_pkg::SLOT_SETUP][5];
    assign detect_mode_lo = state_ff.regs[modem_setup_pkg::SLOT_SETUP][4];
    assign loop_sel_hi    = state_ff.regs[modem_setup_pkg::SLOT_SETUP][3];
    assign loop_sel_lo    = state_ff.regs[modem_setup_pkg::SLOT_SETUP][2];
    assign clock_sel_hi   = state_ff.regs[modem_setup_pkg::SLOT_SETUP][1];
    assign clock_sel_lo   = state_ff.regs[modem_setup_pkg::SLOT_SETUP][0];
    assign zero_power        = state_ff.zero_pwr;
    assign analog_loop_route = state_ff.analog_loop;
    assign rx_amp_break      = state_ff.analog_loop;
    assign tone_ctrl     = state_ff.regs[modem_setup_pkg::SLOT_TONE];
    assign gain_ctrl     = state_ff.regs[modem_setup_pkg::SLOT_GAIN];
    assign char_format   = state_ff.regs[modem_setup_pkg::SLOT_FORMAT];
    assign tx_mod_mode   = state_ff.regs[modem_setup_pkg::SLOT_TX_MOD];
    assign rx_demod_mode = state_ff.regs[modem_setup_pkg::SLOT_RX_DEMOD];
    assign tx_byte_free  = !state_ff.tx_pending;
    assign loop_rx_byte  = state_ff.rx_byte;
    assign loop_rx_ready = state_ff.rx_ready;
    assign irq           = state_ff.irq;
endmodule

//--- logic/serial_cmd_host.sv
// Purpose: Host end that sends set-up commands over the serial command bus.
// Assumes: Software uses the plain command port; writes while busy are dropped.
// Notes:   Fixes set-up bit 7, the detection band bits and the restart wait itself.
`timescale 1ns/1ps
module serial_cmd_host #(
    parameter int SETTLE_CYCLES = modem_setup_pkg::SETTLE_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    serial_cmd_if.host      bus
);
    localparam int SW = modem_setup_pkg::SETTLE_W;

    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP, H_SETTLE} host_state_type;

    typedef struct packed {
        host_state_type st;
        logic [7:0]     target;
        logic [7:0]     data;
        logic [15:0]    sh;
        logic [4:0]     left;
        logic [2:0]     phase;
        logic           sclk;
        logic           sel_n;
        logic           dout;
        logic [7:0]     rdata;
        logic [1:0]     detect;
        logic [1:0]     clk_mode;
        logic           settle_arm;
        logic [SW-1:0]  settle_cnt;
    } host_type;

    host_type   state_ff;
    host_type   nxt_state;
    logic [7:0] d;

    always_comb begin
        nxt_state = state_ff;
        d         = wdata;
        if (wr && state_ff.st == H_IDLE) begin
            case (addr)
                modem_setup_pkg::HOST_TARGET_OFS: begin
                    nxt_state.target = wdata;
                end
                modem_setup_pkg::HOST_DATA_OFS: begin
                    if (state_ff.target == modem_setup_pkg::SETUP_ADDR) begin
                        // [R4] reserved bit forced low
                        d[modem_setup_pkg::SETUP_RESERVED_BIT] = 1'b0;
                        nxt_state.detect   = d[modem_setup_pkg::SETUP_DETECT_LSB +: 2];
                        nxt_state.clk_mode = d[modem_setup_pkg::SETUP_CLOCK_LSB +: 2];
                        // [R14] arm restart wait
                        nxt_state.settle_arm = state_ff.clk_mode == modem_setup_pkg::CLK_ZERO_POWER
                            && d[1:0] != modem_setup_pkg::CLK_ZERO_POWER;
                    end
                    if (state_ff.target == modem_setup_pkg::RX_DEMOD_ADDR
                        && (state_ff.detect == modem_setup_pkg::DET_PROGRESS
                            || state_ff.detect == modem_setup_pkg::DET_ANSWER)) begin
                        // [R7] [R8] band and enable for detection
                        d[modem_setup_pkg::RX_ENABLE_BIT] = 1'b1;
                        d[modem_setup_pkg::RX_BAND_BIT]   =
                            state_ff.detect == modem_setup_pkg::DET_ANSWER;
                    end
                    nxt_state.data = wdata;
                    // [R1] address then one data byte
                    nxt_state.sh   = {state_ff.target, d};
                    nxt_state.left = 5'd16;
                    nxt_state.st   = H_SHIFT;
                end
                modem_setup_pkg::HOST_RESET_OFS: begin
                    // [R2] address-only reset command
                    nxt_state.sh       = {modem_setup_pkg::GENERAL_RESET_ADDR, 8'h00};
                    nxt_state.left     = 5'd8;
                    nxt_state.st       = H_SHIFT;
                    nxt_state.detect   = 2'h0;
                    nxt_state.clk_mode = 2'h0;
                end
                default: begin
                end
            endcase
            if (nxt_state.st == H_SHIFT) begin
                nxt_state.sel_n = 1'b0;
                nxt_state.sclk  = 1'b0;
                nxt_state.phase = 3'h0;
                nxt_state.dout  = nxt_state.sh[15];
            end
        end

        case (state_ff.st)
            H_SHIFT: begin
                nxt_state.phase = state_ff.phase + 3'h1;
                if (state_ff.phase == 3'(modem_setup_pkg::SCLK_HALF - 1)) begin
                    nxt_state.phase = 3'h0;
                    nxt_state.sclk  = !state_ff.sclk;
                    if (state_ff.sclk) begin
                        nxt_state.sh   = {state_ff.sh[14:0], 1'b0};
                        nxt_state.dout = state_ff.sh[14];
                        nxt_state.left = state_ff.left - 5'd1;
                        if (state_ff.left == 5'd1) begin
                            nxt_state.st    = H_GAP;
                            nxt_state.sel_n = 1'b1;
                        end
                    end
                end
            end
            H_GAP: begin
                nxt_state.phase = state_ff.phase + 3'h1;
                if (state_ff.phase == 3'(modem_setup_pkg::SCLK_HALF - 1)) begin
                    nxt_state.phase      = 3'h0;
                    nxt_state.st         = state_ff.settle_arm ? H_SETTLE : H_IDLE;
                    nxt_state.settle_arm = 1'b0;
                    nxt_state.settle_cnt = '0;
                end
            end
            H_SETTLE: begin
                // [R14] hold off until oscillator and bias settle
                nxt_state.settle_cnt = state_ff.settle_cnt + SW'(1);
                if (state_ff.settle_cnt == SW'(SETTLE_CYCLES - 1)) begin
                    nxt_state.st = H_IDLE;
                end
            end
            default: begin
            end
        endcase

        if (rd) begin
            case (addr)
                modem_setup_pkg::HOST_TARGET_OFS: nxt_state.rdata = state_ff.target;
                modem_setup_pkg::HOST_DATA_OFS:   nxt_state.rdata = state_ff.data;
                modem_setup_pkg::HOST_STATUS_OFS: begin
                    nxt_state.rdata = 8'h00;
                    nxt_state.rdata[modem_setup_pkg::HOST_BUSY_BIT]   = state_ff.st != H_IDLE;
                    nxt_state.rdata[modem_setup_pkg::HOST_SETTLE_BIT] = state_ff.st == H_SETTLE;
                end
                default: nxt_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff       <= '0;
            state_ff.sel_n <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata        = state_ff.rdata;
    assign bus.sclk     = state_ff.sclk;
    assign bus.cmd_data = state_ff.dout;
    assign bus.sel_n    = state_ff.sel_n;
endmodule

//--- dv/modem_setup_chk.sv
// Purpose: Timing checks on the serial command bus wires.
// Assumes: One clock, synchronous reset.
// Notes:   Host alone drives the wires.
`timescale 1ns/1ps
module modem_setup_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cmd_data,
    input wire logic sel_n
);
    logic [4:0] bits_ff;
    logic       sclk_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Counting rises within a select tells whole frames from torn ones.
    always_ff @(posedge mclk) begin
        sclk_ff <= sclk;
        bits_ff <= (rst || sel_n) ? 5'h00 : bits_ff + 5'(sclk && !sclk_ff);
    end
    frame_length_a: assert property ($rose(sel_n) |-> bits_ff == 5'h08 || bits_ff == 5'h10)
        else $error("frame not 8 or 16 bits");
    idle_clock_a: assert property (sel_n |-> !sclk) else $error("clock runs while idle");
    high_phase_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("clock high phase not 4");
    low_phase_a: assert property ($fell(sclk) && !sel_n |-> !sclk[*4])
        else $error("clock low phase short");
    select_lead_a: assert property ($fell(sel_n) |-> !sclk[*4] ##1 sclk)
        else $error("first rise misplaced");
    frame_gap_a: assert property ($rose(sel_n) |-> sel_n[*4]) else $error("gap short");
    data_launch_a: assert property (!sel_n && $changed(cmd_data) |-> $fell(sclk) || $fell(sel_n))
        else $error("data moved off falling edge");
    data_hold_a: assert property (sclk |-> $stable(cmd_data)) else $error("data moved while high");
endmodule

//--- dv/modem_setup_control_registers_tb_top.sv
// Purpose: Bench for host and register bank joined by the serial bus.
// Assumes: Bit time 8 and settle time 20 cycles.
// Notes:   The bank is write-only, so its outputs serve as readback.
`timescale 1ns/1ps
module modem_setup_control_registers_tb_top;
    logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rx_byte_taken = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, status_in = 8'h00, rdata, v, tone, gain, fmt, txm, rxm, lrb;
    logic        oe, dh, dl, lh, ll, ch, cl, zp, alr, rab, lrr, irq, tbf;
    int          n_mismatch = 0, compares = 0;
    serial_cmd_if bus_if ();
    serial_cmd_host #(.SETTLE_CYCLES(20)) i_serial_cmd_host (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus(bus_if.host));
    modem_setup_device #(.BIT_CYCLES(8)) i_modem_setup_device (.mclk(mclk), .rst(rst),
        .bus(bus_if.dev), .status_in(status_in), .rx_byte_taken(rx_byte_taken),
        .hook_relay_output_o(), .hook_relay_output_oe(oe), .detect_mode_hi(dh),
        .detect_mode_lo(dl), .loop_sel_hi(lh), .loop_sel_lo(ll), .clock_sel_hi(ch),
        .clock_sel_lo(cl), .zero_power(zp), .analog_loop_route(alr), .rx_amp_break(rab),
        .tone_ctrl(tone), .gain_ctrl(gain), .char_format(fmt), .tx_mod_mode(txm),
        .rx_demod_mode(rxm), .tx_byte_free(tbf), .loop_rx_byte(lrb), .loop_rx_ready(lrr),
        .irq(irq));
    modem_setup_chk i_modem_setup_chk (.mclk(mclk), .rst(rst), .sclk(bus_if.sclk),
        .cmd_data(bus_if.cmd_data), .sel_n(bus_if.sel_n));
    initial forever #2 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge mclk) wr <= 1'b0;
    endtask
    task automatic get(input logic [3:0] a);
        @(posedge mclk) {addr, rd} <= {a, 1'b1};
        @(posedge mclk) rd <= 1'b0;
        @(posedge mclk) v = rdata;
    endtask
    // Busy also covers the restart wait, so polling it bounds every transfer.
    task automatic idle();
        v = 8'h01;
        for (int i = 0; i < 400 && v[0] !== 1'b0; i++) get(modem_setup_pkg::HOST_STATUS_OFS);
        chk(v & 8'h01, 8'h00);
    endtask
    task automatic send(input logic [7:0] t, input logic [7:0] d);
        put(modem_setup_pkg::HOST_TARGET_OFS, t);
        put(modem_setup_pkg::HOST_DATA_OFS, d);
        idle();
    endtask
    task automatic stat(input logic [7:0] s);
        @(posedge mclk) status_in <= s;
        repeat (3) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        send(modem_setup_pkg::SETUP_ADDR, 8'hD9);
        chk({oe, dh, dl, lh, ll, ch, cl, zp}, 8'hB2);
        send(modem_setup_pkg::RX_DEMOD_ADDR, 8'h00);
        chk(rxm, 8'h02);
        send(modem_setup_pkg::TX_BYTE_ADDR, 8'hA5);
        for (int i = 0; i < 200 && lrr !== 1'b1; i++) @(posedge mclk);
        chk(lrb, 8'hA5);
        @(posedge mclk) rx_byte_taken <= 1'b1;
        @(posedge mclk) rx_byte_taken <= 1'b0;
        @(posedge mclk) chk({6'h00, tbf, lrr}, 8'h02);
        $display("setup and digital loop test done");
        send(modem_setup_pkg::SETUP_ADDR, 8'h36);
        chk({4'h0, alr, rab, ch, cl}, 8'h0E);
        send(modem_setup_pkg::SETUP_ADDR, 8'h33);
        chk({4'h0, alr, rab, ch, cl}, 8'h03);
        for (int i = 4; i >= 0; i--) begin
            send(8'(40'hE1E2E4E7E8 >> (8 * i)), 8'(40'h5AC33C7E81 >> (8 * i)));
        end
        send(8'hE5, 8'hFF);
        for (int i = 4; i >= 0; i--) begin
            chk(8'({tone, gain, fmt, txm, rxm} >> (8 * i)), 8'(40'h5AC33C7E81 >> (8 * i)));
        end
        $display("register test done");
        send(modem_setup_pkg::MASK_ADDR, 8'h41);
        stat(8'h01);
        chk({7'h00, irq}, 8'h01);
        stat(8'hBE);
        chk({7'h00, irq}, 8'h00);
        send(modem_setup_pkg::SETUP_ADDR, 8'h00);
        stat(8'h01);
        chk({6'h00, zp, irq}, 8'h02);
        stat(8'h40);
        chk({7'h00, irq}, 8'h01);
        put(modem_setup_pkg::HOST_RESET_OFS, 8'h00);
        idle();
        stat(8'hFF);
        chk(tone | gain | fmt | txm | rxm | {oe, 6'h00, irq}, 8'h00);
        $display("interrupt and general reset test done");
        summarize();
    end
endmodule
